// file: hmrs_consts.vh
// Constants for the host MAC receive status and stop block
`ifndef HMRS_CONSTS_VH
`define HMRS_CONSTS_VH
// Register offsets on the plain register port
`define HMRS_OFS_CTRL        4'h0
`define HMRS_OFS_INTERRUPT_STATUS_REG     4'h1
`define HMRS_OFS_STS_POP     4'h2
`define HMRS_OFS_DATA_POP    4'h3
`define HMRS_OFS_FIFO_INF    4'h4
// Control register fields
`define HMRS_CTRL_RECEIVE_ENABLE_BIT   0
`define HMRS_CTRL_PASS_BAD_FRAMES_BIT 1
`define HMRS_CTRL_RST        2'h0
// Interrupt status fields (write one to clear)
`define HMRS_INT_RXSTOP_BIT  0
`define HMRS_INT_RXERR_BIT   1
// Status word field positions
`define HMRS_ST_FILT_BIT     30
`define HMRS_ST_LEN_HI       29
`define HMRS_ST_LEN_LO       16
`define HMRS_ST_ES_BIT       15
`define HMRS_ST_BCAST_BIT    13
`define HMRS_ST_LENERR_BIT   12
`define HMRS_ST_RUNT_BIT     11
`define HMRS_ST_MCAST_BIT    10
`define HMRS_ST_LONG_BIT     7
`define HMRS_ST_LATECOL_BIT  6
`define HMRS_ST_TYPE_BIT     5
`define HMRS_ST_WDOG_BIT     4
`define HMRS_ST_MIIERR_BIT   3
`define HMRS_ST_DRIB_BIT     2
`define HMRS_ST_CRC_BIT      1
// Frame size limits in bytes, plus the minimum dribble bit count at 10 Mbps
`define HMRS_COLL_WINDOW     14'd64
`define HMRS_MAX_FRAME       14'd1518
`define HMRS_MAX_LENTYPE     16'd1500
`define HMRS_MIN_HDR         14'd14
`define HMRS_WDOG_LIMIT      14'd2048
`define HMRS_DRIB_MIN_10M    3'd3
`endif

// file: hmrs_rx_status.v
// Host MAC receive status word builder, status FIFO and receiver stop logic
//
// Overview of operation
// - Reserved status bits 31, 14, 9:8 and 0 always read zero.
// - Bit 30 set when the frame failed address filtering.
// - Bits 29:16 carry the received frame length in bytes.
// - Bit 15 is the OR of runt, too-long, late-collision and CRC bits.
// - Bit 13 set for a broadcast destination.
// - Bit 12 set when actual length differs from a length/type field of 1500 or less.
// - Bit 11 set when a frame ends before 64 bytes.
// - Runt status words reach the host only when pass-bad-frames is set; runt data words are always counted.
// - Bit 10 set for a multicast destination.
// - Bit 7 flags frames over 1518 bytes, frame is not truncated.
// - Bit 6 set for a collision after the collision window.
// - Bit 5 set when length/type exceeds 1500, never for runts under 14.
// - Bit 4 set when the frame grows past the watchdog limit before its last byte.
// - Bit 3 set when a receive error occurs anywhere in the frame.
// - Bit 2 for odd bits, at 10 Mbps only with 3 or more, not with bit 6.
// - Bit 1 on CRC mismatch or receive error during the frame.
// - On actual halt pulse and latch the receiver-stopped flag.
// - Receiver error flag on data/status underrun or status overrun; keep going.
// - Status word is pushed only after all frame data is written.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "hmrs_consts.vh"

module hmrs_rx_status #(
	parameter STS_DEPTH_LOG2 = 4,
	parameter DATA_CNT_W     = 12
) (
	// Clock and reset
	input  wire        CLK,
	input  wire        RST_B,
	// Register port
	input  wire [3:0]  REG_ADDR,
	input  wire [31:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [31:0] REG_RDATA,
	// Receive frame events from the MAC interface layer
	input  wire        FRAME_START,
	input  wire        BYTE_VALID,
	input  wire        DATA_WORD_WR,
	input  wire        FRAME_END,
	input  wire [2:0]  DRIBBLE_BITS,
	input  wire        RX_ERR,
	input  wire        COLLISION,
	input  wire        CRC_OK,
	input  wire        FILTER_FAIL,
	input  wire        DEST_BCAST,
	input  wire        DEST_MCAST,
	input  wire [15:0] LEN_TYPE,
	input  wire        LEN_TYPE_VALID,
	input  wire        SPEED_10M,
	// Receive control and events to the rest of the MAC
	output wire        RECEIVE_ENABLE,
	output wire        PASS_BAD_FRAMES,
	output wire        RX_ACTIVE,
	output reg         RECEIVER_STOPPED_IRQ,
	output wire        RECEIVER_ERROR_FLAG,
	output wire        RX_DATA_POP
);

	localparam STS_DEPTH = 1 << STS_DEPTH_LOG2;

	// Receive state machine, one-hot
	localparam ST_IDLE    = 3'b001;
	localparam ST_FRAME   = 3'b010;
	localparam ST_STOPPED = 3'b100;

	// ==========================================================
	// Register and state declarations
	reg [1:0]  ctrl_reg;
	reg [1:0]  interrupt_status_reg_reg;
	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg [13:0] len_reg;
	reg        rxerr_seen_reg;
	reg        col_late_reg;
	reg        wdog_reg;
	reg [31:0] sts_mem [0:STS_DEPTH-1];
	reg [STS_DEPTH_LOG2:0] wr_ptr_reg;
	reg [STS_DEPTH_LOG2:0] rd_ptr_reg;
	reg [DATA_CNT_W-1:0]   data_cnt_reg;
	reg [31:0] status_word;

	wire [STS_DEPTH_LOG2:0] sts_level = wr_ptr_reg - rd_ptr_reg;
	wire sts_empty = (sts_level == {(STS_DEPTH_LOG2+1){1'b0}});
	wire sts_full  = sts_level[STS_DEPTH_LOG2];
	wire [13:0] len_now = len_reg + {13'h0000, BYTE_VALID};

	// Register port decodes
	wire wr_ctrl   = REG_WR && (REG_ADDR == `HMRS_OFS_CTRL);
	wire wr_int    = REG_WR && (REG_ADDR == `HMRS_OFS_INTERRUPT_STATUS_REG);
	wire sts_pop   = REG_RD && (REG_ADDR == `HMRS_OFS_STS_POP);
	wire data_pop  = REG_RD && (REG_ADDR == `HMRS_OFS_DATA_POP);

	// Frame end and classification
	wire end_now   = (state_reg == ST_FRAME) && FRAME_END;
	wire is_runt   = len_now < `HMRS_COLL_WINDOW;
	// drop runts unless passing bad frames
	wire drop_now  = is_runt && !ctrl_reg[`HMRS_CTRL_PASS_BAD_FRAMES_BIT];

	// Error events
	wire sts_uflow  = sts_pop && sts_empty;
	wire data_uflow = data_pop && (data_cnt_reg == {DATA_CNT_W{1'b0}});
	wire sts_oflow  = end_now && !drop_now && sts_full;
	wire push       = end_now && !drop_now && !sts_full;

	assign RECEIVE_ENABLE      = ctrl_reg[`HMRS_CTRL_RECEIVE_ENABLE_BIT];
	assign PASS_BAD_FRAMES     = ctrl_reg[`HMRS_CTRL_PASS_BAD_FRAMES_BIT];
	assign RX_ACTIVE           = (state_reg == ST_FRAME);
	assign RECEIVER_ERROR_FLAG = interrupt_status_reg_reg[`HMRS_INT_RXERR_BIT];
	assign RX_DATA_POP         = data_pop && !data_uflow;

	// ==========================================================
	// Status word assembly
	always @* begin
		status_word = 32'h00000000;
		status_word[`HMRS_ST_FILT_BIT] = FILTER_FAIL;
		status_word[`HMRS_ST_LEN_HI:`HMRS_ST_LEN_LO] = len_now;
		status_word[`HMRS_ST_BCAST_BIT] = DEST_BCAST;
		status_word[`HMRS_ST_MCAST_BIT] = DEST_MCAST;
		// length mismatch, only for length-style field
		status_word[`HMRS_ST_LENERR_BIT] = LEN_TYPE_VALID
			&& (LEN_TYPE <= `HMRS_MAX_LENTYPE)
			&& ({2'b00, len_now} != LEN_TYPE);
		status_word[`HMRS_ST_RUNT_BIT] = is_runt;
		status_word[`HMRS_ST_LONG_BIT] = len_now > `HMRS_MAX_FRAME;
		status_word[`HMRS_ST_LATECOL_BIT] = col_late_reg;
		status_word[`HMRS_ST_TYPE_BIT] = LEN_TYPE_VALID && (len_now >= `HMRS_MIN_HDR)
			&& (LEN_TYPE > `HMRS_MAX_LENTYPE);
		status_word[`HMRS_ST_WDOG_BIT] = wdog_reg;
		status_word[`HMRS_ST_MIIERR_BIT] = rxerr_seen_reg || RX_ERR;
		status_word[`HMRS_ST_DRIB_BIT] = !col_late_reg && (DRIBBLE_BITS != 3'd0)
			&& (!SPEED_10M || (DRIBBLE_BITS >= `HMRS_DRIB_MIN_10M));
		status_word[`HMRS_ST_CRC_BIT] = !CRC_OK || rxerr_seen_reg || RX_ERR;
		status_word[`HMRS_ST_ES_BIT] = status_word[`HMRS_ST_RUNT_BIT]
			| status_word[`HMRS_ST_LONG_BIT] | status_word[`HMRS_ST_LATECOL_BIT]
			| status_word[`HMRS_ST_CRC_BIT];
	end

	// ==========================================================
	// Receive state machine
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (!ctrl_reg[`HMRS_CTRL_RECEIVE_ENABLE_BIT])
					state_next = ST_STOPPED;
				else if (FRAME_START)
					state_next = ST_FRAME;
			end
			ST_FRAME: begin
				if (FRAME_END)
					state_next = ctrl_reg[`HMRS_CTRL_RECEIVE_ENABLE_BIT] ? ST_IDLE : ST_STOPPED;
			end
			ST_STOPPED: begin
				if (ctrl_reg[`HMRS_CTRL_RECEIVE_ENABLE_BIT])
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// State register and receiver-stopped pulse
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= ST_STOPPED;
			RECEIVER_STOPPED_IRQ <= 1'b0;
		end else begin
			state_reg <= state_next;
			RECEIVER_STOPPED_IRQ <= (state_next == ST_STOPPED) && (state_reg != ST_STOPPED);
		end
	end

	// ==========================================================
	// Per-frame accumulators
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			len_reg <= 14'h0000;
			rxerr_seen_reg <= 1'b0;
			col_late_reg <= 1'b0;
			wdog_reg <= 1'b0;
		end else if (state_reg != ST_FRAME) begin
			len_reg <= 14'h0000;
			rxerr_seen_reg <= 1'b0;
			col_late_reg <= 1'b0;
			wdog_reg <= 1'b0;
		end else begin
			// Length saturates so a runaway frame cannot wrap the field
			if (BYTE_VALID && (len_reg != 14'h3FFF))
				len_reg <= len_now;
			if (RX_ERR)
				rxerr_seen_reg <= 1'b1;
			if (COLLISION && !(len_reg < `HMRS_COLL_WINDOW))
				col_late_reg <= 1'b1;
			if (len_now > `HMRS_WDOG_LIMIT)
				wdog_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Status FIFO
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_ptr_reg <= {(STS_DEPTH_LOG2+1){1'b0}};
			rd_ptr_reg <= {(STS_DEPTH_LOG2+1){1'b0}};
		end else begin
			// push at frame end, after data
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (sts_pop && !sts_empty)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	// entry written once, untouched until popped
	always @(posedge CLK) begin
		if (push)
			sts_mem[wr_ptr_reg[STS_DEPTH_LOG2-1:0]] <= status_word;
	end

	// Data FIFO word count: written by the MAC, popped by the host
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			data_cnt_reg <= {DATA_CNT_W{1'b0}};
		else if (DATA_WORD_WR && !RX_DATA_POP)
			data_cnt_reg <= data_cnt_reg + 1'b1;
		else if (!DATA_WORD_WR && RX_DATA_POP)
			data_cnt_reg <= data_cnt_reg - 1'b1;
	end

	// ==========================================================
	// Control and interrupt status registers
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg <= `HMRS_CTRL_RST;
			interrupt_status_reg_reg <= 2'b00;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= REG_WDATA[1:0];
			// Write one to clear; a new event in the same cycle wins
			if (wr_int)
				interrupt_status_reg_reg <= interrupt_status_reg_reg & ~REG_WDATA[1:0];
			if ((state_next == ST_STOPPED) && (state_reg != ST_STOPPED))
				interrupt_status_reg_reg[`HMRS_INT_RXSTOP_BIT] <= 1'b1;
			if (sts_uflow || data_uflow || sts_oflow)
				interrupt_status_reg_reg[`HMRS_INT_RXERR_BIT] <= 1'b1;
		end
	end

	// ==========================================================
	// Read data, one cycle after the strobe
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			REG_RDATA <= 32'h00000000;
		else if (REG_RD) begin
			case (REG_ADDR)
				`HMRS_OFS_CTRL:    REG_RDATA <= {30'h0, ctrl_reg};
				`HMRS_OFS_INTERRUPT_STATUS_REG: REG_RDATA <= {30'h0, interrupt_status_reg_reg};
				`HMRS_OFS_STS_POP: REG_RDATA <= sts_empty ? 32'h00000000
					: sts_mem[rd_ptr_reg[STS_DEPTH_LOG2-1:0]];
				`HMRS_OFS_FIFO_INF: REG_RDATA <= {8'h00,
					{(8-STS_DEPTH_LOG2-1){1'b0}}, sts_level,
					{(16-DATA_CNT_W){1'b0}}, data_cnt_reg};
				default:           REG_RDATA <= 32'h00000000;
			endcase
		end else
			REG_RDATA <= 32'h00000000;
	end

endmodule // hmrs_rx_status

// file: hmrs_rx_status_props.sv
// Checker for the receive status block, bound to its ports
`timescale 1ns/1ns
`include "hmrs_consts.vh"
module hmrs_rx_status_props #(
	parameter STS_DEPTH_LOG2 = 4,
	parameter DATA_CNT_W     = 12
) (
	// Clock and reset
	input wire        CLK,
	input wire        RST_B,
	// Register port
	input wire [3:0]  REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire        REG_WR,
	input wire        REG_RD,
	input wire [31:0] REG_RDATA,
	// Receive control and events
	input wire        FRAME_END,
	input wire        RECEIVE_ENABLE,
	input wire        RX_ACTIVE,
	input wire        RECEIVER_STOPPED_IRQ,
	input wire        RECEIVER_ERROR_FLAG,
	input wire        RX_DATA_POP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Length field of whatever the read port shows
	wire [13:0] len_seen = REG_RDATA[29:16];
	// ==================================================
	// Status pops: a zero word is an empty pop, so skip it
	sequence s_pop;
		REG_RD && REG_ADDR == `HMRS_OFS_STS_POP ##1 len_seen != 14'h0;
	endsequence
	sequence s_end_off;
		RX_ACTIVE && FRAME_END && !RECEIVE_ENABLE;
	endsequence
	chk_reserved_zero: assert property (s_pop |-> (REG_RDATA & 32'h8000_4301) == 32'h0)
		else $error("reserved status bit set");
	chk_error_summary: assert property (s_pop |-> REG_RDATA[15] ==
		(REG_RDATA[11] | REG_RDATA[7] | REG_RDATA[6] | REG_RDATA[1]))
		else $error("error summary wrong");
	chk_runt_flag: assert property ((s_pop ##0 len_seen < 14'd64) |-> REG_RDATA[11])
		else $error("short frame without runt bit");
	chk_type_runt: assert property ((s_pop ##0 len_seen < 14'd14) |-> !REG_RDATA[5])
		else $error("type bit on tiny frame");
	chk_long_flag: assert property ((s_pop ##0 len_seen > 14'd1518) |-> REG_RDATA[7])
		else $error("long frame not flagged");
	chk_wdog_flag: assert property ((s_pop ##0 len_seen > 14'd2048) |-> REG_RDATA[4])
		else $error("watchdog bit missing");
	chk_drib_latecol: assert property (s_pop |-> !(REG_RDATA[2] && REG_RDATA[6]))
		else $error("dribble with late collision");
	chk_enable_write: assert property (REG_WR && REG_ADDR == `HMRS_OFS_CTRL |=>
		RECEIVE_ENABLE == $past(REG_WDATA[0]))
		else $error("receive enable not written");
	chk_stop_pulse: assert property ($rose(RECEIVER_STOPPED_IRQ) |=> !RECEIVER_STOPPED_IRQ)
		else $error("stop pulse too long");
	chk_stop_after_end: assert property (s_end_off |-> ##[1:2] RECEIVER_STOPPED_IRQ)
		else $error("no stop after last frame");
	chk_stop_idle: assert property (RECEIVER_STOPPED_IRQ |-> !RX_ACTIVE)
		else $error("stop reported mid frame");
	chk_underrun_err: assert property (REG_RD && REG_ADDR == `HMRS_OFS_DATA_POP &&
		!RX_DATA_POP |-> ##[1:2] RECEIVER_ERROR_FLAG)
		else $error("data underrun not flagged");
	chk_pop_source: assert property (RX_DATA_POP |-> REG_RD && REG_ADDR == `HMRS_OFS_DATA_POP)
		else $error("data pop without read");
endmodule // hmrs_rx_status_props

bind hmrs_rx_status hmrs_rx_status_props #(
	.STS_DEPTH_LOG2(STS_DEPTH_LOG2),
	.DATA_CNT_W(DATA_CNT_W)
) u_props (
	.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FRAME_END(FRAME_END),
	.RECEIVE_ENABLE(RECEIVE_ENABLE), .RX_ACTIVE(RX_ACTIVE),
	.RECEIVER_STOPPED_IRQ(RECEIVER_STOPPED_IRQ),
	.RECEIVER_ERROR_FLAG(RECEIVER_ERROR_FLAG), .RX_DATA_POP(RX_DATA_POP)
);

// file: hmrs_mil_model.sv
// Behavioural receive side model that streams one frame per request
`timescale 1ns/1ns
module hmrs_mil_model (
	// Clock and reset
	input wire        CLK,
	input wire        RST_B,
	// Request from the bench
	input wire        GO,
	input wire [13:0] LEN,
	input wire        LATE_COLL,
	output reg        BUSY,
	// Frame events
	output reg        FRAME_START,
	output reg        BYTE_VALID,
	output reg        DATA_WORD_WR,
	output reg        FRAME_END,
	output reg        COLLISION
);
	reg  [13:0] cnt_reg;
	wire        run  = BUSY && !FRAME_END;
	wire        last = cnt_reg + 14'h1 == LEN;
	// One byte a cycle, a data word every fourth byte and at the end
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			{BUSY, FRAME_START, BYTE_VALID, DATA_WORD_WR, FRAME_END, COLLISION} <= 6'h0;
			cnt_reg <= 14'h0;
		end else begin
			FRAME_START  <= GO && !BUSY;
			BUSY         <= GO || run;
			BYTE_VALID   <= run;
			FRAME_END    <= run && last;
			DATA_WORD_WR <= run && (last || cnt_reg[1:0] == 2'h3);
			// Collision only well past the 64 byte window
			COLLISION    <= run && LATE_COLL && cnt_reg > 14'd70;
			cnt_reg      <= GO ? 14'h0 : cnt_reg + {13'h0, run};
		end
	end
endmodule // hmrs_mil_model

// file: tb.sv
// Self-checking bench for the receive status block
`timescale 1ns/1ns
`include "hmrs_consts.vh"
module tb;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [3:0]  addr = 4'h0;
	reg  [31:0] wdata = 32'h0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg         go = 1'b0;
	reg  [13:0] flen = 14'h0;
	reg  [9:0]  fl = 10'h0;
	reg  [15:0] ltype = 16'h0;
	reg         ltv = 1'b1;
	wire        pbf;
	reg  [31:0] v;
	wire [31:0] rdata;
	wire        busy, fs, bv, dw, fe, coll, stop_irq, err_flag;
	integer     n_fail = 0;
	integer     checks_done = 0;
	integer     n_stop = 0;
	integer     i, j, n;

	always #50 clk = ~clk;

	// Flag bits: late, 10M, dribble[2:0], rx error, bad crc, filter, bcast, mcast
	hmrs_mil_model mil (.CLK(clk), .RST_B(rst_b), .GO(go), .LEN(flen), .LATE_COLL(fl[9]),
		.BUSY(busy), .FRAME_START(fs), .BYTE_VALID(bv), .DATA_WORD_WR(dw), .FRAME_END(fe),
		.COLLISION(coll));
	hmrs_rx_status dut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .FRAME_START(fs), .BYTE_VALID(bv),
		.DATA_WORD_WR(dw), .FRAME_END(fe), .DRIBBLE_BITS(fl[7:5]), .RX_ERR(fl[4]),
		.COLLISION(coll), .CRC_OK(!fl[3]), .FILTER_FAIL(fl[2]), .DEST_BCAST(fl[1]),
		.DEST_MCAST(fl[0]), .LEN_TYPE(ltype), .LEN_TYPE_VALID(ltv), .SPEED_10M(fl[8]),
		.RECEIVE_ENABLE(), .PASS_BAD_FRAMES(pbf), .RX_ACTIVE(), .RECEIVER_STOPPED_IRQ(stop_irq),
		.RECEIVER_ERROR_FLAG(err_flag), .RX_DATA_POP());

	// Count stop pulses so a one-cycle pulse is never missed
	always @(posedge clk)
		if (stop_irq === 1'b1)
			n_stop <= n_stop + 1;

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH index %0h exp %h seen %h", addr, exp, seen);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_fail);
			if (n_fail == 0 && checks_done > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// A gap cycle after each write keeps strobes from being driven twice at one edge
	task wr_reg(input [3:0] a, input [31:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Mask of zero only captures the value
	task rd_reg(input [3:0] a, input [31:0] m, input [31:0] e);
		begin
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(posedge clk);
			v = rdata;
			if (m != 32'h0)
				chk(v & m, e);
		end
	endtask
	task frame(input [13:0] l, input [9:0] f, input [15:0] lt);
		begin
			flen <= l;
			fl <= f;
			ltype <= lt;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			for (i = 0; i < 3000 && (busy || i == 0); i = i + 1)
				@(posedge clk);
			if (busy) begin
				n_fail = n_fail + 1;
				test_done;
			end
		end
	endtask
	task pf(input [13:0] l, input [9:0] f, input [15:0] lt, input [31:0] e);
		begin
			frame(l, f, lt);
			rd_reg(`HMRS_OFS_STS_POP, 32'hFFFF_FFFF, {2'b00, l, 16'h0} | e);
		end
	endtask

	// ==================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_reg(`HMRS_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
		rd_reg(`HMRS_OFS_INTERRUPT_STATUS_REG, 32'hFFFF_FFFF, 32'h0);
		rd_reg(4'hF, 32'hFFFF_FFFF, 32'h0);
		wr_reg(`HMRS_OFS_CTRL, 32'h1);
		wr_reg(4'hF, 32'hFFFF_FFFF);
		rd_reg(`HMRS_OFS_CTRL, 32'hFFFF_FFFF, 32'h1);
		pf(100, 10'h002, 16'h0800, 32'h0000_2020);
		pf(100, 10'h141, 16'd50, 32'h0000_1400);
		pf(100, 10'h160, 16'h0800, 32'h0000_0024);
		pf(100, 10'h020, 16'h0800, 32'h0000_0024);
		ltv <= 1'b0;
		pf(100, 10'h000, 16'd50, 32'h0000_0000);
		ltv <= 1'b1;
		pf(100, 10'h2A0, 16'h0800, 32'h0000_8060);
		pf(1600, 10'h014, 16'h0800, 32'h4000_80AA);
		pf(2100, 10'h000, 16'h0800, 32'h0000_80B0);
		pf(100, 10'h008, 16'h0800, 32'h0000_8022);
		frame(10, 10'h000, 16'h0800);
		rd_reg(`HMRS_OFS_FIFO_INF, 32'h00FF_0000, 32'h0);
		wr_reg(`HMRS_OFS_CTRL, 32'h3);
		chk(pbf, 1);
		pf(10, 10'h000, 16'h0800, 32'h0000_8800);
		// Stop in mid-frame: the frame still completes with its status
		fork
			frame(100, 10'h000, 16'h0800);
			begin
				repeat (20) @(posedge clk);
				wr_reg(`HMRS_OFS_CTRL, 32'h2);
				rd_reg(`HMRS_OFS_FIFO_INF, 32'h00FF_0000, 32'h0);
			end
		join
		repeat (3) @(posedge clk);
		chk(n_stop, 1);
		rd_reg(`HMRS_OFS_INTERRUPT_STATUS_REG, 32'h1, 32'h1);
		rd_reg(`HMRS_OFS_STS_POP, 32'hFFFF_FFFF, 32'h0064_0020);
		wr_reg(`HMRS_OFS_CTRL, 32'h1);
		wr_reg(`HMRS_OFS_CTRL, 32'h0);
		// Pulse lands one edge later and the counter one more
		repeat (3) @(posedge clk);
		chk(n_stop, 2);
		wr_reg(`HMRS_OFS_CTRL, 32'h1);
		// Overrun the status queue, then underrun it and the data queue
		for (j = 0; j < 17; j = j + 1)
			frame(64, 10'h000, 16'h0800);
		rd_reg(`HMRS_OFS_FIFO_INF, 32'h00FF_0000, 32'h0010_0000);
		chk(err_flag, 1);
		wr_reg(`HMRS_OFS_INTERRUPT_STATUS_REG, 32'h2);
		chk(err_flag, 0);
		for (j = 0; j < 16; j = j + 1)
			rd_reg(`HMRS_OFS_STS_POP, 32'h3FFF_0000, 32'h0040_0000);
		rd_reg(`HMRS_OFS_STS_POP, 32'hFFFF_FFFF, 32'h0);
		chk(err_flag, 1);
		wr_reg(`HMRS_OFS_INTERRUPT_STATUS_REG, 32'h2);
		rd_reg(`HMRS_OFS_FIFO_INF, 32'h0, 32'h0);
		n = v[11:0];
		for (j = 0; j < n; j = j + 1)
			rd_reg(`HMRS_OFS_DATA_POP, 32'h0, 32'h0);
		chk(err_flag, 0);
		rd_reg(`HMRS_OFS_DATA_POP, 32'h0, 32'h0);
		chk(err_flag, 1);
		// reset after the underrun restores a clean state
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_reg(`HMRS_OFS_INTERRUPT_STATUS_REG, 32'hFFFF_FFFF, 32'h0);
		rd_reg(`HMRS_OFS_FIFO_INF, 32'hFFFF_FFFF, 32'h0);
		rd_reg(`HMRS_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
		test_done;
	end
endmodule // tb
